// File: ibsm_chk_monitor.sv
// concurrent checks on the request status monitor ports
`include "ibsm_regs.vh"
module ibsm_chk #(
  parameter ADDR_W = 12
) (
  input wire logic              i_clk,
  input wire logic              i_rst_n,
  input wire logic              i_flash_ready_flash_stall_req,
  input wire logic [ADDR_W-1:0] i_s_axi_araddr,
  input wire logic              i_s_axi_arvalid,
  input wire logic              o_s_axi_arready,
  input wire logic              o_s_axi_rvalid,
  input wire logic              i_s_axi_rready,
  input wire logic [31:0]       o_s_axi_rdata,
  input wire logic              i_s_axi_awvalid,
  input wire logic              o_s_axi_awready,
  input wire logic              i_s_axi_wvalid,
  input wire logic              o_s_axi_wready,
  input wire logic              o_s_axi_bvalid
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  wire rd_hs = i_s_axi_arvalid && o_s_axi_arready;
  wire [ADDR_W-1:0] ra = i_s_axi_araddr;
  vec49_upper_a: assert property (
    rd_hs && ra == `IBSM_OFF_VEC49 |=> o_s_axi_rdata[31:3] == 0)
    else $error("vector49 word has upper bits set");
  vec53_upper_a: assert property (
    rd_hs && ra == `IBSM_OFF_VEC53 |=> o_s_axi_rdata[31:7] == 0)
    else $error("vector53 word has upper bits set");
  vec54_upper_a: assert property (
    rd_hs && ra == `IBSM_OFF_VEC54 |=> o_s_axi_rdata[31:8] == 0)
    else $error("vector54 word has upper bits set");
  vec62_upper_a: assert property (
    rd_hs && ra == `IBSM_OFF_VEC62 |=> o_s_axi_rdata[31:16] == 0)
    else $error("vector62 word has upper bits set");
  vec63_upper_a: assert property (
    rd_hs && ra == `IBSM_OFF_VEC63 |=> o_s_axi_rdata[31:12] == 0)
    else $error("vector63 word has upper bits set");
  // a request held for two edges has crossed the two-stage synchroniser
  flash_bit_a: assert property (
    i_rst_n && i_flash_ready_flash_stall_req ##1 i_flash_ready_flash_stall_req
    ##1 (rd_hs && ra == `IBSM_OFF_VEC63) |=> o_s_axi_rdata[11])
    else $error("flash request missing from vector63 word");
  flash_clear_a: assert property (
    !i_flash_ready_flash_stall_req ##1 !i_flash_ready_flash_stall_req
    ##1 (rd_hs && ra == `IBSM_OFF_VEC63) |=> !o_s_axi_rdata[11])
    else $error("flash bit set with no request");
  read_answer_a: assert property (
    rd_hs |=> o_s_axi_rvalid)
    else $error("read not answered next cycle");
  read_hold_a: assert property (
    o_s_axi_rvalid && !i_s_axi_rready |=>
    o_s_axi_rvalid && $stable(o_s_axi_rdata))
    else $error("read answer dropped or changed before taken");
  write_answer_a: assert property (
    i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready
    |=> o_s_axi_bvalid)
    else $error("write not answered next cycle");
endmodule // ibsm_chk
bind ibsm_monitor ibsm_chk #(
  .ADDR_W(ADDR_W)
) chk_u (
  .i_clk                  (i_clk),
  .i_rst_n                (i_rst_n),
  .i_flash_ready_flash_stall_req (i_flash_ready_flash_stall_req),
  .i_s_axi_araddr         (i_s_axi_araddr),
  .i_s_axi_arvalid        (i_s_axi_arvalid),
  .o_s_axi_arready        (o_s_axi_arready),
  .o_s_axi_rvalid         (o_s_axi_rvalid),
  .i_s_axi_rready         (i_s_axi_rready),
  .o_s_axi_rdata          (o_s_axi_rdata),
  .i_s_axi_awvalid        (i_s_axi_awvalid),
  .o_s_axi_awready        (o_s_axi_awready),
  .i_s_axi_wvalid         (i_s_axi_wvalid),
  .o_s_axi_wready         (o_s_axi_wready),
  .o_s_axi_bvalid         (o_s_axi_bvalid)
);

// File: ibsm_monitor.v
// batch request status monitor with an axi4-lite register slave
// Contract
// [RULE_01] vector49: bit2 mac one power mgmt, bit1 bus dma, bit0 can one.
// [RULE_02] one status word per vector gathers all its requests.
// [RULE_03] vector50 bits4:0 show usb zero endpoint 5..1 data requests.
// [RULE_04] a request steered to dma reads as zero.
// [RULE_05] vector51 bits5:0 carry usb zero status groups and endpoint zero.
// [RULE_06] vector52 bit5 shows remote receiver zero request.
// [RULE_07] vector52 bits4:0 show usb one endpoint 5..1 data requests.
// [RULE_08] vector53 bit6 shows remote receiver one request.
// [RULE_09] vector53 bits5:0 carry usb one status in usb zero order.
// [RULE_10] vector54 bits7:0 show dma channel 7..0 completion.
// [RULE_11] vector57 bits5:0 show quadrature counter one requests.
// [RULE_12] vector62 bits15:0: timers 15..8, odd second, even first request.
// [RULE_13] pwm mode: first underflow or duty match, second start trigger.
// [RULE_14] pulse or reload mode: first underflow, second start trigger.
// [RULE_15] capture mode: first overflow, second measurement end.
// [RULE_16] vector63 bit11 shows flash ready or stall request.
// [RULE_17] unassigned upper bits read zero.
// [RULE_18] bits follow source levels unlatched; writes to status words ignored.
// [RULE_19] handlers must clear requests at the source before returning.
//
// The implementer's own choices: the address map and the AXI4-Lite interface to the registers.
`include "ibsm_regs.vh"

module ibsm_monitor #(
  parameter ADDR_W = 12
) (
  input  wire                    i_clk,
  input  wire                    i_rst_n,
  input  wire [2:0]              i_vec49_req,
  input  wire [4:0]              i_usb_zero_ep_req,
  input  wire [5:0]              i_usb_zero_req_group,
  input  wire                    i_remote_rx_zero_req,
  input  wire [4:0]              i_usb_one_ep_req,
  input  wire [5:0]              i_usb_one_req_group,
  input  wire                    i_remote_rx_one_req,
  input  wire [7:0]              i_dma_channel_req_group,
  input  wire [5:0]              i_quad_counter_one_req_group,
  input  wire [15:0]             i_base_timer_req_group,
  input  wire                    i_flash_ready_flash_stall_req,
  input  wire [ADDR_W-1:0]       i_s_axi_awaddr,
  input  wire                    i_s_axi_awvalid,
  output wire                    o_s_axi_awready,
  input  wire [31:0]             i_s_axi_wdata,
  input  wire [3:0]              i_s_axi_wstrb,
  input  wire                    i_s_axi_wvalid,
  output wire                    o_s_axi_wready,
  output reg  [1:0]              o_s_axi_bresp,
  output reg                     o_s_axi_bvalid,
  input  wire                    i_s_axi_bready,
  input  wire [ADDR_W-1:0]       i_s_axi_araddr,
  input  wire                    i_s_axi_arvalid,
  output wire                    o_s_axi_arready,
  output reg  [31:0]             o_s_axi_rdata,
  output reg  [1:0]              o_s_axi_rresp,
  output reg                     o_s_axi_rvalid,
  input  wire                    i_s_axi_rready
);

  // request lines come from other clock domains: two flip-flops each.
  // every group is a level, so a bit that crosses a cycle after its
  // neighbours only shows a cycle late; nothing here is held
  reg  [2:0]  m_vec49;
  reg  [2:0]  s_vec49;
  reg  [4:0]  m_usb0_ep;
  reg  [4:0]  s_usb0_ep;
  reg  [5:0]  m_usb0_st;
  reg  [5:0]  s_usb0_st;
  reg         m_rem0;
  reg         s_rem0;
  reg  [4:0]  m_usb1_ep;
  reg  [4:0]  s_usb1_ep;
  reg  [5:0]  m_usb1_st;
  reg  [5:0]  s_usb1_st;
  reg         m_rem1;
  reg         s_rem1;
  reg  [7:0]  m_dma;
  reg  [7:0]  s_dma;
  reg  [5:0]  m_quad;
  reg  [5:0]  s_quad;
  reg  [15:0] m_timer;
  reg  [15:0] s_timer;
  reg         m_flash;
  reg         s_flash;

  // [RULE_18] level follow, unlatched
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      m_vec49 <= 3'h0;
      s_vec49 <= 3'h0;
    end else begin
      m_vec49 <= i_vec49_req;
      s_vec49 <= m_vec49;
    end
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      m_usb0_ep <= 5'h00;
      s_usb0_ep <= 5'h00;
    end else begin
      m_usb0_ep <= i_usb_zero_ep_req;
      s_usb0_ep <= m_usb0_ep;
    end
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      m_usb0_st <= 6'h00;
      s_usb0_st <= 6'h00;
    end else begin
      m_usb0_st <= i_usb_zero_req_group;
      s_usb0_st <= m_usb0_st;
    end
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      m_rem0 <= 1'h0;
      s_rem0 <= 1'h0;
    end else begin
      m_rem0 <= i_remote_rx_zero_req;
      s_rem0 <= m_rem0;
    end
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      m_usb1_ep <= 5'h00;
      s_usb1_ep <= 5'h00;
    end else begin
      m_usb1_ep <= i_usb_one_ep_req;
      s_usb1_ep <= m_usb1_ep;
    end
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      m_usb1_st <= 6'h00;
      s_usb1_st <= 6'h00;
    end else begin
      m_usb1_st <= i_usb_one_req_group;
      s_usb1_st <= m_usb1_st;
    end
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      m_rem1 <= 1'h0;
      s_rem1 <= 1'h0;
    end else begin
      m_rem1 <= i_remote_rx_one_req;
      s_rem1 <= m_rem1;
    end
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      m_dma <= 8'h00;
      s_dma <= 8'h00;
    end else begin
      m_dma <= i_dma_channel_req_group;
      s_dma <= m_dma;
    end
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      m_quad <= 6'h00;
      s_quad <= 6'h00;
    end else begin
      m_quad <= i_quad_counter_one_req_group;
      s_quad <= m_quad;
    end
  end

  // [2k+1] second and [2k] first request of timer channel 8+k
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      m_timer <= 16'h0000;
      s_timer <= 16'h0000;
    end else begin
      m_timer <= i_base_timer_req_group;
      s_timer <= m_timer;
    end
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      m_flash <= 1'h0;
      s_flash <= 1'h0;
    end else begin
      m_flash <= i_flash_ready_flash_stall_req;
      s_flash <= m_flash;
    end
  end

  // dma steer select: usb0 ep 4:0, usb1 ep 9:5, timer channel 8..15 at 17:10
  // (one bit per timer channel masks both of its requests)
  reg [`IBSM_W_STEER-1:0] dma_request_steer_select;
  wire [4:0] steer_usb0 = dma_request_steer_select[`IBSM_STEER_USB0_LSB +: 5];
  wire [4:0] steer_usb1 = dma_request_steer_select[`IBSM_STEER_USB1_LSB +: 5];
  wire [7:0] steer_tmr  = dma_request_steer_select[`IBSM_STEER_TMR_LSB +: 8];

  function [15:0] pair_mask;
    input [7:0] ch;
    integer k;
    begin
      pair_mask = 16'h0000;
      for (k = 0; k < 8; k = k + 1) begin
        pair_mask[2*k]   = ch[k];
        pair_mask[2*k+1] = ch[k];
      end
    end
  endfunction

  // status words; the timer's mode decides what first/second mean
  // [RULE_13] [RULE_14] [RULE_15] are the source timer's own encoding
  // [RULE_02] one word per vector
  // [RULE_01] vector49 mapping
  wire [31:0] w_vec49 = {29'h0, s_vec49};
  // [RULE_03] usb zero endpoints
  // [RULE_04] steered bits forced zero
  wire [31:0] w_vec50 = {27'h0, s_usb0_ep & ~steer_usb0};
  // [RULE_05] usb zero status groups
  wire [31:0] w_vec51 = {26'h0, s_usb0_st};
  // [RULE_06] remote zero at bit5
  // [RULE_07] usb one endpoints
  wire [31:0] w_vec52 = {26'h0, s_rem0, s_usb1_ep & ~steer_usb1};
  // [RULE_08] remote one at bit6
  // [RULE_09] usb one status
  wire [31:0] w_vec53 = {25'h0, s_rem1, s_usb1_st};
  // [RULE_10] dma channels
  wire [31:0] w_vec54 = {24'h0, s_dma};
  // [RULE_11] quadrature counter
  wire [31:0] w_vec57 = {26'h0, s_quad};
  // [RULE_12] timer pairs
  wire [31:0] w_vec62 = {16'h0, s_timer & ~pair_mask(steer_tmr)};
  // [RULE_16] flash at bit11
  // [RULE_17] upper bits zero
  wire [31:0] w_vec63 = {20'h0, s_flash, 11'h0};

  // ---------------- axi4-lite write path ----------------
  reg              aw_held;
  reg              w_held;
  reg [ADDR_W-1:0] aw_addr;
  reg [31:0]       w_data;
  reg [3:0]        w_strb;

  assign o_s_axi_awready = !aw_held && !o_s_axi_bvalid;
  assign o_s_axi_wready  = !w_held && !o_s_axi_bvalid;

  wire aw_take = i_s_axi_awvalid && o_s_axi_awready;
  wire w_take  = i_s_axi_wvalid && o_s_axi_wready;
  wire aw_ok   = aw_held || aw_take;
  wire w_ok    = w_held || w_take;
  wire [ADDR_W-1:0] wr_addr = aw_held ? aw_addr : i_s_axi_awaddr;
  wire [31:0]       wr_data = w_held ? w_data : i_s_axi_wdata;
  wire [3:0]        wr_strb = w_held ? w_strb : i_s_axi_wstrb;
  wire              wr_go   = aw_ok && w_ok && !o_s_axi_bvalid;

  function is_status;
    input [ADDR_W-1:0] a;
    begin
      if (a == `IBSM_OFF_VEC49 || a == `IBSM_OFF_VEC50 ||
          a == `IBSM_OFF_VEC51 || a == `IBSM_OFF_VEC52 ||
          a == `IBSM_OFF_VEC53 || a == `IBSM_OFF_VEC54 ||
          a == `IBSM_OFF_VEC57 || a == `IBSM_OFF_VEC62 ||
          a == `IBSM_OFF_VEC63)
        is_status = 1'b1;
      else
        is_status = 1'b0;
    end
  endfunction

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aw_held                  <= 1'b0;
      w_held                   <= 1'b0;
      aw_addr                  <= {ADDR_W{1'b0}};
      w_data                   <= `IBSM_RST_WORD;
      w_strb                   <= 4'h0;
      o_s_axi_bvalid           <= 1'b0;
      o_s_axi_bresp            <= `IBSM_RESP_OKAY;
    end else begin
      if (o_s_axi_bvalid && i_s_axi_bready)
        o_s_axi_bvalid <= 1'b0;
      if (wr_go) begin
        aw_held        <= 1'b0;
        w_held         <= 1'b0;
        o_s_axi_bvalid <= 1'b1;
        if (wr_addr == `IBSM_OFF_STEER) begin
          o_s_axi_bresp <= `IBSM_RESP_OKAY;
        end else if (is_status(wr_addr)) begin
          // [RULE_18] status words ignore writes
          o_s_axi_bresp <= `IBSM_RESP_OKAY;
        end else begin
          o_s_axi_bresp <= `IBSM_RESP_SLVERR;
        end
      end else begin
        if (aw_take) begin
          aw_held <= 1'b1;
          aw_addr <= i_s_axi_awaddr;
        end
        if (w_take) begin
          w_held <= 1'b1;
          w_data <= i_s_axi_wdata;
          w_strb <= i_s_axi_wstrb;
        end
      end
    end
  end

  // steer select: the write strobe picks byte lanes; bits above the
  // documented groups are kept for software but mask nothing
  wire steer_we = wr_go && (wr_addr == `IBSM_OFF_STEER);

  integer b;
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dma_request_steer_select <= {`IBSM_W_STEER{1'h0}};
    end else if (steer_we) begin
      for (b = 0; b < `IBSM_W_STEER; b = b + 1)
        if (wr_strb[b/8])
          dma_request_steer_select[b] <= wr_data[b];
    end
  end

  // ---------------- axi4-lite read path ----------------
  assign o_s_axi_arready = !o_s_axi_rvalid;

  reg [31:0] rd_word;
  reg [1:0]  rd_resp;
  always @* begin
    rd_resp = `IBSM_RESP_OKAY;
    rd_word = `IBSM_RST_WORD;
    if (i_s_axi_araddr == `IBSM_OFF_VEC49)
      rd_word = w_vec49;
    else if (i_s_axi_araddr == `IBSM_OFF_VEC50)
      rd_word = w_vec50;
    else if (i_s_axi_araddr == `IBSM_OFF_VEC51)
      rd_word = w_vec51;
    else if (i_s_axi_araddr == `IBSM_OFF_VEC52)
      rd_word = w_vec52;
    else if (i_s_axi_araddr == `IBSM_OFF_VEC53)
      rd_word = w_vec53;
    else if (i_s_axi_araddr == `IBSM_OFF_VEC54)
      rd_word = w_vec54;
    else if (i_s_axi_araddr == `IBSM_OFF_VEC57)
      rd_word = w_vec57;
    else if (i_s_axi_araddr == `IBSM_OFF_VEC62)
      rd_word = w_vec62;
    else if (i_s_axi_araddr == `IBSM_OFF_VEC63)
      rd_word = w_vec63;
    else if (i_s_axi_araddr == `IBSM_OFF_STEER)
      rd_word = {{(32-`IBSM_W_STEER){1'b0}}, dma_request_steer_select};
    else
      rd_resp = `IBSM_RESP_SLVERR;
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata  <= `IBSM_RST_WORD;
      o_s_axi_rresp  <= `IBSM_RESP_OKAY;
    end else if (i_s_axi_arvalid && o_s_axi_arready) begin
      o_s_axi_rvalid <= 1'b1;
      o_s_axi_rdata  <= rd_word;
      o_s_axi_rresp  <= rd_resp;
    end else if (o_s_axi_rvalid && i_s_axi_rready) begin
      o_s_axi_rvalid <= 1'b0;
    end
  end

endmodule // ibsm_monitor

// File: ibsm_regs.vh
// register offsets, field positions and widths of the request status monitor
`ifndef IBSM_REGS_VH
`define IBSM_REGS_VH

`define IBSM_OFF_VEC49      12'h000
`define IBSM_OFF_VEC50      12'h004
`define IBSM_OFF_VEC51      12'h008
`define IBSM_OFF_VEC52      12'h00C
`define IBSM_OFF_VEC53      12'h010
`define IBSM_OFF_VEC54      12'h014
`define IBSM_OFF_VEC57      12'h018
`define IBSM_OFF_VEC62      12'h01C
`define IBSM_OFF_VEC63      12'h020
`define IBSM_OFF_STEER      12'h024

`define IBSM_W_VEC49        3
`define IBSM_W_USB_EP       5
`define IBSM_W_USB_STAT     6
`define IBSM_W_DMA          8
`define IBSM_W_QUAD         6
`define IBSM_W_TIMER        16
`define IBSM_W_STEER        26

`define IBSM_BIT_REMOTE0    5
`define IBSM_BIT_REMOTE1    6
`define IBSM_BIT_FLASH      11

`define IBSM_STEER_USB0_LSB 0
`define IBSM_STEER_USB1_LSB 5
`define IBSM_STEER_TMR_LSB  10

`define IBSM_RESP_OKAY      2'h0
`define IBSM_RESP_SLVERR    2'h2
`define IBSM_RST_WORD       32'h00000000

`endif

// File: ibsm_req_src.sv
// peripheral side model: level request lines held until cleared
module ibsm_req_src (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic [57:0] i_set,
  input  wire logic [57:0] i_clr,
  output logic      [57:0] o_req
);
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) o_req <= '0;
    else o_req <= (o_req & ~i_clr) | i_set;
  end
endmodule // ibsm_req_src

// File: irq_batch_status_monitor_tb.sv
// self-checking bench for the request status monitor
`include "ibsm_regs.vh"
module irq_batch_status_monitor_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 0, rst_n = 0, awv = 0, wv = 0, bre = 0, arv = 0;
  logic        rre = 0;
  logic [57:0] set_v = '0, clr_v = '0, req;
  logic [11:0] awa = '0, ara = '0;
  logic [31:0] wd = '0, rd;
  logic [25:0] steer = '0;
  logic [1:0]  resp;
  logic [3:0]  ws = 4'hF;
  wire         awr, wr, bv, arr, rv;
  wire  [1:0]  br, rr;
  wire  [31:0] rdat;
  int          err_count = 0, checks_done = 0;
  logic [11:0] offs [10] = '{`IBSM_OFF_VEC49, `IBSM_OFF_VEC50,
    `IBSM_OFF_VEC51, `IBSM_OFF_VEC52, `IBSM_OFF_VEC53, `IBSM_OFF_VEC54,
    `IBSM_OFF_VEC57, `IBSM_OFF_VEC62, `IBSM_OFF_VEC63, `IBSM_OFF_STEER};
  initial forever #2.5 clk = ~clk;
  ibsm_req_src src_u (.i_clk(clk), .i_rst_n(rst_n), .i_set(set_v),
    .i_clr(clr_v), .o_req(req));
  ibsm_monitor dut_u (.i_clk(clk), .i_rst_n(rst_n),
    .i_vec49_req(req[2:0]), .i_usb_zero_ep_req(req[7:3]),
    .i_usb_zero_req_group(req[13:8]), .i_remote_rx_zero_req(req[14]),
    .i_usb_one_ep_req(req[19:15]), .i_usb_one_req_group(req[25:20]),
    .i_remote_rx_one_req(req[26]), .i_dma_channel_req_group(req[34:27]),
    .i_quad_counter_one_req_group(req[40:35]),
    .i_base_timer_req_group(req[56:41]), .i_flash_ready_flash_stall_req(req[57]),
    .i_s_axi_awaddr(awa), .i_s_axi_awvalid(awv), .o_s_axi_awready(awr),
    .i_s_axi_wdata(wd), .i_s_axi_wstrb(ws), .i_s_axi_wvalid(wv),
    .o_s_axi_wready(wr), .o_s_axi_bresp(br), .o_s_axi_bvalid(bv),
    .i_s_axi_bready(bre), .i_s_axi_araddr(ara), .i_s_axi_arvalid(arv),
    .o_s_axi_arready(arr), .o_s_axi_rdata(rdat), .o_s_axi_rresp(rr),
    .o_s_axi_rvalid(rv), .i_s_axi_rready(rre));
  function automatic logic [31:0] expw(input int k);
    logic [15:0] m;
    for (int i = 0; i < 8; i++) m[2*i+:2] = {2{steer[10+i]}};
    case (k)
      0: expw = {29'h0, req[2:0]};
      1: expw = {27'h0, req[7:3] & ~steer[4:0]};
      2: expw = {26'h0, req[13:8]};
      3: expw = {26'h0, req[14], req[19:15] & ~steer[9:5]};
      4: expw = {25'h0, req[26], req[25:20]};
      5: expw = {24'h0, req[34:27]};
      6: expw = {26'h0, req[40:35]};
      7: expw = {16'h0, req[56:41] & ~m};
      8: expw = {20'h0, req[57], 11'h0};
      default: expw = {6'h0, steer};
    endcase
  endfunction
  task automatic chk(input string nm, input logic [31:0] s, e);
    checks_done++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic axw(input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    awa <= a; wd <= d; awv <= 1; wv <= 1; bre <= 1;
    do begin
      @(posedge clk);
      n++;
      if (awr) awv <= 0;
      if (wr) wv <= 0;
    end while (!bv && n < 50);
    if (n >= 50) err_count++;
    resp = br;
    bre <= 0;
  endtask
  task automatic axr(input logic [11:0] a);
    int n = 0;
    @(posedge clk);
    ara <= a; arv <= 1; rre <= 1;
    do begin
      @(posedge clk);
      n++;
      if (arr) arv <= 0;
    end while (!rv && n < 50);
    if (n >= 50) err_count++;
    rd = rdat;
    resp = rr;
    rre <= 0;
  endtask
  // source levels settle through the synchroniser before reads
  task automatic src(input logic [57:0] s, c);
    @(posedge clk);
    set_v <= s; clr_v <= c;
    @(posedge clk);
    set_v <= '0; clr_v <= '0;
    repeat (3) @(posedge clk);
  endtask
  task automatic check_all;
    for (int k = 0; k < 10; k++) begin
      axr(offs[k]);
      chk("word", rd, expw(k));
      chk("word bits", rd, expw(k));
      chk("read resp", {30'h0, resp}, 32'h0);
    end
  endtask
  task automatic report_and_stop;
    if (err_count == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    report_and_stop;
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1;
    check_all;
    foreach (offs[p]) begin
      src({29{p[0], ~p[0]}} | {58{p == 3}}, '1);
      check_all;
    end
    for (int t = 0; t < 2; t++) begin
      axw(`IBSM_OFF_STEER, t ? 32'hFFFFFFFF : 32'h00015295);
      steer = t ? 26'h3FFFFFF : 26'h0015295;
      chk("steer resp", {30'h0, resp}, 32'h0);
      check_all;
    end
    ws <= 4'h1;
    axw(`IBSM_OFF_STEER, 32'h0);
    ws <= 4'hF;
    steer = 26'h3FFFF00;
    chk("lane write resp", {30'h0, resp}, 32'h0);
    check_all;
    axw(`IBSM_OFF_VEC50, 32'hFFFFFFFF);
    chk("status write resp", {30'h0, resp}, 32'h0);
    check_all;
    axr(12'h028);
    chk("unmapped data", rd, 32'h0);
    chk("unmapped read", {30'h0, resp}, 32'h2);
    axw(12'h028, 32'h1);
    chk("unmapped write", {30'h0, resp}, 32'h2);
    src('0, '1);
    check_all;
    src('1, '0);
    rst_n <= 0;
    repeat (2) @(posedge clk);
    rst_n <= 1;
    steer = '0;
    check_all;
    report_and_stop;
  end
endmodule // irq_batch_status_monitor_tb
